// ==== hdl/ifce_pkg.sv ====
// constants for the interrupt flag and channel enable block
// assumes an upstream serial port decoder that hands over byte-wide register accesses
// Notes on behaviour
// - enabled parity error sets status 7, irq low
// - enabled self-test done sets status 6, irq low
// - enabled update-set event sets status 5, irq low
// - enabled update-clear event sets status 4, irq low
// - enabled lock gained sets status 3, irq low
// - enabled lock dropped sets status 2, irq low
// - enabled saturation overflow sets status 1, irq low
// - status 7 sticky on parity error, write-one clears
// - status 6 sticky on self-test done, write-one clears
// - status 5 sticky on update set, write-one clears
// - status 4 sticky on update clear, write-one clears
// - status 3 shows lock held, writes ignored
// - status 2 sticky on lock drop, write-one clears
// - status 1 sticky on saturation, write-one clears
// - channel field bits enable matching channels
// - clearing status 1 zeroes saturation counter
// - clearing status 7 zeroes parity counter

package ifce_pkg;

	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned CNT_W  = 8;

	// register offsets
	localparam logic [7:0] SAT_COUNT_ADDR  = 8'h01;
	localparam logic [7:0] PAR_COUNT_ADDR  = 8'h02;
	localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h03;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h04;
	localparam logic [7:0] CHAN_EN_ADDR    = 8'h05;

	// bit positions shared by the enable and status registers
	localparam int unsigned PARITY_BIT   = 7;
	localparam int unsigned SELFTEST_BIT = 6;
	localparam int unsigned PSET_BIT     = 5;
	localparam int unsigned PCLR_BIT     = 4;
	localparam int unsigned LOCK_ACQ_BIT = 3;
	localparam int unsigned LOCK_DRP_BIT = 2;
	localparam int unsigned SAT_BIT      = 1;

	// implemented bits, bit 0 reserved
	localparam logic [7:0] IRQ_BITS_MASK = 8'hfe;
	// bits that clear on a written one; the lock bit does not
	localparam logic [7:0] W1C_MASK      = 8'hf6;
	localparam logic [7:0] CHAN_EN_MASK  = 8'h0f;

	// reset values
	localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
	localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
	localparam logic [7:0] CHAN_EN_RST    = 8'h00;
	localparam logic [7:0] COUNT_RST      = 8'h00;
	localparam logic [7:0] RDATA_RST      = 8'h00;

endpackage

// ==== hdl/ifce_cnt_if.sv ====
// carrier between the flag logic and an event counter
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none

interface ifce_cnt_if #(
	parameter int unsigned WIDTH = 8
);
	logic             inc;
	logic             clr;
	logic [WIDTH-1:0] count;

	modport ctl (
		output inc,
		output clr,
		input  count
	);

	modport cnt (
		input  inc,
		input  clr,
		output count
	);
endinterface

`default_nettype wire

// ==== hdl/ifce_sat_counter.sv ====
// saturating event counter cleared by a write-one strobe
// assumes the increment and clear strobes are synchronous one-cycle pulses
`timescale 1ns/100ps
`default_nettype none

module ifce_sat_counter #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	ifce_cnt_if.cnt   cnt_if
);

	// refused while the design is elaborated, not at run time
	if (WIDTH < 1 || WIDTH > 32) begin
		$error("counter width out of range");
	end

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;

	// an event in the clear cycle counts as the first after the clear
	always_comb begin
		count_nxt = cnt_if.clr ? '0 : count_r;
		if (cnt_if.inc && count_nxt != {WIDTH{1'b1}}) begin
			count_nxt = count_nxt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign cnt_if.count = count_r;

endmodule

`default_nettype wire

// ==== hdl/ifce_top.sv ====
// interrupt enable, interrupt status and channel enable registers
// assumes the serial port decoder presents one-cycle write and read strobes
// and that all event inputs are synchronous one-cycle pulses
`timescale 1ns/100ps
`default_nettype none

module ifce_top #(
	parameter int unsigned CHAN_NUM = 4
) (
	input  wire logic                             ref_clk_i,
	input  wire logic                             rst_n_i,
	// register access from the serial port
	input  wire logic [ifce_pkg::ADDR_W-1:0]      reg_addr_i,
	input  wire logic                             reg_wr_i,
	input  wire logic [ifce_pkg::DATA_W-1:0]      reg_wdata_i,
	input  wire logic                             reg_rd_i,
	output logic      [ifce_pkg::DATA_W-1:0]      reg_rdata_o,
	output logic                                  reg_rvalid_o,
	// event sources
	input  wire logic                             parity_error_flag_i,
	input  wire logic                             selftest_done_flag_i,
	input  wire logic                             param_update_set_event_i,
	input  wire logic                             param_update_clear_event_i,
	input  wire logic                             handoff_lock_gained_i,
	input  wire logic                             handoff_lock_dropped_i,
	input  wire logic                             saturation_error_flag_i,
	// outputs
	output logic                                  irq_n_o,
	output logic      [CHAN_NUM-1:0]              channel_enable_field_o,
	output logic      [ifce_pkg::CNT_W-1:0]       saturation_counter_o,
	output logic      [ifce_pkg::CNT_W-1:0]       parity_error_counter_o
);

	// the register field is four bits wide, so no other count can be served
	if (CHAN_NUM != 4) begin
		$error("channel enable field holds exactly four channels");
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode

	function automatic logic hit(input logic [ifce_pkg::ADDR_W-1:0] a,
		input logic [ifce_pkg::ADDR_W-1:0] target);
		hit = (a == target);
	endfunction

	logic wr_enable;
	logic wr_status;
	logic wr_chan;

	assign wr_enable = reg_wr_i && hit(reg_addr_i, ifce_pkg::IRQ_ENABLE_ADDR);
	assign wr_status = reg_wr_i && hit(reg_addr_i, ifce_pkg::IRQ_STATUS_ADDR);
	assign wr_chan   = reg_wr_i && hit(reg_addr_i, ifce_pkg::CHAN_EN_ADDR);

	////////////////////////////////////////////////////////////////////////////////
	// interrupt enable register

	logic [7:0] irq_enable_r;
	logic [7:0] irq_enable_nxt;

	assign irq_enable_nxt = wr_enable ? (reg_wdata_i & ifce_pkg::IRQ_BITS_MASK) : irq_enable_r;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_enable_r <= ifce_pkg::IRQ_ENABLE_RST;
		end else if (wr_enable) begin
			irq_enable_r <= reg_wdata_i & ifce_pkg::IRQ_BITS_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status register

	logic [7:0] event_vec;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic [7:0] irq_status_r;
	logic [7:0] irq_status_nxt;

	always_comb begin
		event_vec = 8'h00;
		event_vec[ifce_pkg::PARITY_BIT]   = parity_error_flag_i;
		event_vec[ifce_pkg::SELFTEST_BIT] = selftest_done_flag_i;
		event_vec[ifce_pkg::PSET_BIT]     = param_update_set_event_i;
		event_vec[ifce_pkg::PCLR_BIT]     = param_update_clear_event_i;
		event_vec[ifce_pkg::LOCK_ACQ_BIT] = handoff_lock_gained_i;
		event_vec[ifce_pkg::LOCK_DRP_BIT] = handoff_lock_dropped_i;
		event_vec[ifce_pkg::SAT_BIT]      = saturation_error_flag_i;
	end

	// an event only latches while its enable bit is set
	assign set_vec = event_vec & irq_enable_r & ifce_pkg::IRQ_BITS_MASK;

	always_comb begin
		clr_vec = 8'h00;
		if (wr_status) begin
			clr_vec = reg_wdata_i & ifce_pkg::W1C_MASK;
		end
		// the lock bit falls when the handoff is lost
		clr_vec[ifce_pkg::LOCK_ACQ_BIT] = handoff_lock_dropped_i;
	end

	// a set in the clearing cycle wins
	always_comb begin
		irq_status_nxt = ((irq_status_r & ~clr_vec) | set_vec) & ifce_pkg::IRQ_BITS_MASK;
		irq_status_nxt[ifce_pkg::LOCK_DRP_BIT] = irq_status_r[ifce_pkg::LOCK_DRP_BIT] && !clr_vec[ifce_pkg::LOCK_DRP_BIT]
			|| set_vec[ifce_pkg::LOCK_DRP_BIT];
		irq_status_nxt[ifce_pkg::SAT_BIT] = irq_status_r[ifce_pkg::SAT_BIT] && !clr_vec[ifce_pkg::SAT_BIT]
			|| set_vec[ifce_pkg::SAT_BIT];
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_status_r <= ifce_pkg::IRQ_STATUS_RST;
		end else begin
			irq_status_r <= irq_status_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt pin

	logic irq_n_r;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_n_r <= 1'b1;
		end else begin
			// next enable value too, so a disabling write releases the pin in one cycle
			irq_n_r <= ~|(irq_status_nxt & irq_enable_nxt);
		end
	end

	assign irq_n_o = irq_n_r;

	////////////////////////////////////////////////////////////////////////////////
	// channel enable register

	logic [7:0] chan_en_r;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan_en_r <= ifce_pkg::CHAN_EN_RST;
		end else if (wr_chan) begin
			chan_en_r <= reg_wdata_i & ifce_pkg::CHAN_EN_MASK;
		end
	end

	assign channel_enable_field_o = chan_en_r[CHAN_NUM-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// error counters

	ifce_cnt_if #(.WIDTH(ifce_pkg::CNT_W)) sat_cnt_if ();
	ifce_cnt_if #(.WIDTH(ifce_pkg::CNT_W)) par_cnt_if ();

	assign sat_cnt_if.inc = saturation_error_flag_i;
	assign sat_cnt_if.clr = wr_status && reg_wdata_i[ifce_pkg::SAT_BIT];
	assign par_cnt_if.inc = parity_error_flag_i;
	assign par_cnt_if.clr = wr_status && reg_wdata_i[ifce_pkg::PARITY_BIT];

	ifce_sat_counter #(
		.WIDTH (ifce_pkg::CNT_W)
	) u_sat_counter (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.cnt_if    (sat_cnt_if.cnt)
	);

	ifce_sat_counter #(
		.WIDTH (ifce_pkg::CNT_W)
	) u_par_counter (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.cnt_if    (par_cnt_if.cnt)
	);

	assign saturation_counter_o   = sat_cnt_if.count;
	assign parity_error_counter_o = par_cnt_if.count;

	////////////////////////////////////////////////////////////////////////////////
	// read back

	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       rvalid_r;

	always_comb begin
		case (reg_addr_i)
			ifce_pkg::SAT_COUNT_ADDR: begin
				rdata_nxt = sat_cnt_if.count;
			end
			ifce_pkg::PAR_COUNT_ADDR: begin
				rdata_nxt = par_cnt_if.count;
			end
			ifce_pkg::IRQ_ENABLE_ADDR: begin
				rdata_nxt = irq_enable_r;
			end
			ifce_pkg::IRQ_STATUS_ADDR: begin
				rdata_nxt = irq_status_r;
			end
			ifce_pkg::CHAN_EN_ADDR: begin
				rdata_nxt = chan_en_r;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r <= ifce_pkg::RDATA_RST;
		end else if (reg_rd_i) begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd_i;
		end
	end

	assign reg_rdata_o  = rdata_r;
	assign reg_rvalid_o = rvalid_r;

endmodule

`default_nettype wire

// ==== testbench/ifce_top_sva.sv ====
// port assertions for the interrupt flag and channel enable block
// assumes it is bound onto ifce_top with one clock domain
`timescale 1ns/100ps
`default_nettype none

module ifce_top_sva #(
	parameter int unsigned CHAN_NUM = 4
) (
	input wire logic                ref_clk_i,
	input wire logic                rst_n_i,
	input wire logic [7:0]          reg_addr_i,
	input wire logic                reg_wr_i,
	input wire logic [7:0]          reg_wdata_i,
	input wire logic                reg_rd_i,
	input wire logic [7:0]          reg_rdata_o,
	input wire logic                reg_rvalid_o,
	input wire logic                parity_error_flag_i,
	input wire logic                selftest_done_flag_i,
	input wire logic                param_update_set_event_i,
	input wire logic                param_update_clear_event_i,
	input wire logic                handoff_lock_gained_i,
	input wire logic                handoff_lock_dropped_i,
	input wire logic                saturation_error_flag_i,
	input wire logic                irq_n_o,
	input wire logic [CHAN_NUM-1:0] channel_enable_field_o,
	input wire logic [7:0]          saturation_counter_o,
	input wire logic [7:0]          parity_error_counter_o
);
	logic [7:0] en_r;
	wire logic [7:0] evs = {parity_error_flag_i, selftest_done_flag_i, param_update_set_event_i,
		param_update_clear_event_i, handoff_lock_gained_i, handoff_lock_dropped_i, saturation_error_flag_i, 1'b0};
	wire logic en_wr = reg_wr_i && reg_addr_i == 8'h03;
	wire logic st_wr = reg_wr_i && reg_addr_i == 8'h04;

	// shadow of the enable register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			en_r <= 8'h00;
		else if (en_wr)
			en_r <= reg_wdata_i & 8'hfe;
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_event_irq_low: assert property (
		(evs & en_r) != 8'h00 && !en_wr |=> !irq_n_o)
		else $error("enabled event left irq high");
	a_irq_quiet: assert property (en_r == 8'h00 ##1 en_r == 8'h00 |-> irq_n_o)
		else $error("irq low with all enables off");
	a_sat_clear: assert property (
		st_wr && reg_wdata_i[1] && !saturation_error_flag_i |=> saturation_counter_o == 8'h00)
		else $error("saturation counter not cleared");
	a_par_clear: assert property (
		st_wr && reg_wdata_i[7] && !parity_error_flag_i |=> parity_error_counter_o == 8'h00)
		else $error("parity counter not cleared");
	a_sat_count: assert property (
		saturation_error_flag_i && !(st_wr && reg_wdata_i[1]) && saturation_counter_o != 8'hff
		|=> saturation_counter_o == $past(saturation_counter_o) + 8'h01)
		else $error("saturation counter missed a count");
	a_chan_write: assert property (
		reg_wr_i && reg_addr_i == 8'h05 |=> channel_enable_field_o == $past(reg_wdata_i[3:0]))
		else $error("channel enables differ from write");
	a_chan_hold: assert property (
		!(reg_wr_i && reg_addr_i == 8'h05) |=> $stable(channel_enable_field_o))
		else $error("channel enables changed without write");
	a_rd_unmapped: assert property (
		reg_rd_i && (reg_addr_i > 8'h05 || reg_addr_i == 8'h00) |=> reg_rvalid_o && reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
endmodule

bind ifce_top ifce_top_sva #(.CHAN_NUM(CHAN_NUM)) u_ifce_top_sva (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
	.reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .parity_error_flag_i, .selftest_done_flag_i,
	.param_update_set_event_i, .param_update_clear_event_i, .handoff_lock_gained_i, .handoff_lock_dropped_i,
	.saturation_error_flag_i, .irq_n_o, .channel_enable_field_o, .saturation_counter_o, .parity_error_counter_o);

`default_nettype wire

// ==== testbench/ifce_top_tb.sv ====
// self-checking bench for the interrupt flag and channel enable block
// assumes the one-cycle strobe register port and pulse event inputs
`timescale 1ns/100ps
`default_nettype none

module ifce_top_tb;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic       wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic       rd = 1'b0;
	logic [7:0] ev = 8'h00;
	logic [7:0] rdata;
	logic       rvalid;
	logic       irq_n;
	logic [3:0] chan;
	logic [7:0] satc;
	logic [7:0] parc;
	int         err_total = 0;
	int         compares = 0;
	int         b;

	initial begin
		forever #2.5 clk = ~clk;
	end

	ifce_top #(.CHAN_NUM(4)) u_ifce_top (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.parity_error_flag_i(ev[7]), .selftest_done_flag_i(ev[6]), .param_update_set_event_i(ev[5]),
		.param_update_clear_event_i(ev[4]), .handoff_lock_gained_i(ev[3]), .handoff_lock_dropped_i(ev[2]),
		.saturation_error_flag_i(ev[1]), .irq_n_o(irq_n), .channel_enable_field_o(chan),
		.saturation_counter_o(satc), .parity_error_counter_o(parc));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({rvalid, rdata}, {1'b1, e});
	endtask

	task automatic pulse(input logic [7:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 8'h00;
		#1;
	endtask

	task automatic end_sim;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		err_total++;
		end_sim;
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({8'h00, irq_n}, 9'h001);
		rd_reg(8'h04, 8'h00);
		rd_reg(8'h00, 8'h00);
		rd_reg(8'h06, 8'h00);
		wr_reg(8'h03, 8'hff);
		rd_reg(8'h03, 8'hfe);
		// read data holds while the valid strobe lasts one cycle only
		@(posedge clk);
		#1;
		chk({rvalid, rdata}, 9'h0fe);
		for (b = 0; b < 16; b++) begin
			wr_reg(8'h05, {4'hf, b[3:0]});
			chk({5'h00, chan}, {5'h00, b[3:0]});
		end
		rd_reg(8'h05, 8'h0f);
		// lock gained stays set until the lock drop event
		for (b = 7; b > 0; b--) begin
			pulse(8'h01 << b);
			chk({8'h00, irq_n}, 9'h000);
			rd_reg(8'h04, 8'h01 << b);
			wr_reg(8'h04, 8'h01 << b);
			rd_reg(8'h04, (b == 3) ? 8'h08 : 8'h00);
			chk({8'h00, irq_n}, {8'h00, b != 3});
		end
		// an event in the clearing cycle wins over the clear
		@(posedge clk);
		ev <= 8'h80;
		wr <= 1'b1;
		addr <= 8'h04;
		wdata <= 8'h80;
		@(posedge clk);
		ev <= 8'h00;
		wr <= 1'b0;
		#1;
		chk({8'h00, irq_n}, 9'h000);
		chk({1'b0, parc}, 9'h001);
		rd_reg(8'h04, 8'h80);
		wr_reg(8'h04, 8'h80);
		wr_reg(8'h03, 8'h00);
		pulse(8'hfe);
		rd_reg(8'h04, 8'h00);
		wr_reg(8'h03, 8'h02);
		pulse(8'h02);
		chk({8'h00, irq_n}, 9'h000);
		wr_reg(8'h03, 8'h00);
		chk({8'h00, irq_n}, 9'h001);
		rd_reg(8'h04, 8'h02);
		wr_reg(8'h04, 8'h82);
		chk({1'b0, satc}, 9'h000);
		pulse(8'h82);
		pulse(8'h82);
		pulse(8'h02);
		rd_reg(8'h01, 8'h03);
		rd_reg(8'h02, 8'h02);
		wr_reg(8'h04, 8'h02);
		chk({1'b0, satc}, 9'h000);
		chk({1'b0, parc}, 9'h002);
		wr_reg(8'h04, 8'h80);
		chk({1'b0, parc}, 9'h000);
		@(posedge clk);
		ev <= 8'h02;
		repeat (260) @(posedge clk);
		ev <= 8'h00;
		wr_reg(8'h01, 8'h00);
		rd_reg(8'h01, 8'hff);
		end_sim;
	end
endmodule

`default_nettype wire
